/* common/vic_pkg.sv */
// Constants, offsets and carrier types of the vectored interrupt controller
package vic_pkg;

   // =====================================================
   // Address decode
   localparam logic [31:0] BASE_ADDR = 32'hFFFF0000;
   localparam logic [31:0] REGION_MASK = 32'hFFFFF000;
   localparam int OFS_W = 12;

   // =====================================================
   // Register offsets
   localparam logic [11:0] OFS_NSTA = 12'h000;
   localparam logic [11:0] OFS_NSIG = 12'h004;
   localparam logic [11:0] OFS_NEN = 12'h008;
   localparam logic [11:0] OFS_NDIS = 12'h00C;
   localparam logic [11:0] OFS_SWI = 12'h010;
   localparam logic [11:0] OFS_BASE = 12'h014;
   localparam logic [11:0] OFS_NVEC = 12'h01C;
   localparam logic [11:0] OFS_PLOW = 12'h020;
   localparam logic [11:0] OFS_PMID = 12'h024;
   localparam logic [11:0] OFS_PHIGH = 12'h028;
   localparam logic [11:0] OFS_RSVD = 12'h02C;
   localparam logic [11:0] OFS_NEST = 12'h030;
   localparam logic [11:0] OFS_TRIG = 12'h034;
   localparam logic [11:0] OFS_ECLR = 12'h038;
   localparam logic [11:0] OFS_NSTAN = 12'h03C;
   localparam logic [11:0] OFS_FSTA = 12'h100;
   localparam logic [11:0] OFS_FSIG = 12'h104;
   localparam logic [11:0] OFS_FEN = 12'h108;
   localparam logic [11:0] OFS_FDIS = 12'h10C;
   localparam logic [11:0] OFS_FVEC = 12'h11C;
   localparam logic [11:0] OFS_FSTAN = 12'h13C;

   // =====================================================
   // Reset values and fields
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam int NUM_SRC = 32;
   localparam int NUM_EXT = 4;
   localparam int EXT_LSB = 16;
   localparam int PRIO_W = 3;
   localparam int FIELD_W = 4;
   localparam int LOW_FIRST = 1;
   localparam int MID_FIRST = 8;
   localparam int HIGH_FIRST = 16;
   localparam int HIGH_LAST = 21;
   localparam logic [2:0] PRIO_NONE = 3'h7;
   localparam int TRIG_W = 2;
   localparam logic [1:0] TRIG_LEVEL = 2'h0;
   localparam logic [1:0] TRIG_RISE = 2'h1;
   localparam logic [1:0] TRIG_FALL = 2'h2;
   localparam int NEST_IRQ_BIT = 0;
   localparam int NEST_FIQ_BIT = 1;
   localparam int VEC_SHIFT = 1;
   localparam logic [3:0] STAN_IDLE = 4'h0;

   // =====================================================
   // Carrier types
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } vic_apb_req_type;

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } vic_apb_rsp_type;

   // In-service record: valid flag above level
   typedef struct packed {
      logic valid;
      logic [2:0] lvl;
   } vic_stan_type;

   typedef struct packed {
      logic found;
      logic [4:0] idx;
      logic [2:0] lvl;
   } vic_win_type;

endpackage

/* core/vic_core.sv */
// Vectored normal/fast interrupt controller with peripheral bus register file
//
// What this block does
// - Peripheral bus register access completes in two cycles, setup then access.
// - The controller sits on the peripheral bus, not the system bus.
// - Registers decode from base address 0xFFFF0000.
// - Normal raw register shows every source state, enabled or not.
// - Writing normal disable clears selected enable bits only.
// - Software interrupt register lets software raise sources itself.
// - Vector base register points to 64-byte table, resets to zero.
// - Normal vector returns handler of highest-priority active source.
// - Sources 1 to 21 have priority level 0 to 7; all other sources are fixed at level 7.
// - First priority register holds sources 1 to 7.
// - Second priority register holds sources 8 to 15.
// - Third priority register holds sources 16 to 21.
// - Nesting enabled separately for normal and fast; off after reset.
// - External inputs trigger on rising edge, falling edge or level.
// - Edge triggers latch; edge-clear write drops the pending request.
// - Normal exception entry records the causing priority level.
// - Fast raw register shows every source state, enabled or not.
// - Writing fast disable clears selected fast enable bits.
// - Fast exception entry records the causing priority level.
// - Fast request takes precedence over normal request.
`timescale 1ns/1ps

module vic_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Peripheral bus
   input wire vic_pkg::vic_apb_req_type apb_req,
   output vic_pkg::vic_apb_rsp_type apb_rsp,
   // Interrupt sources
   input wire logic [31:0] src_in,
   input wire logic [3:0] ext_in,
   // Processor core
   input wire logic irq_ack,
   input wire logic fiq_ack,
   output logic irq_req,
   output logic fiq_req
);

   // ======================================================
   // Functions
   function automatic logic [2:0] prio_of(input logic [4:0] i, input logic [31:0] p0,
                                          input logic [31:0] p1, input logic [31:0] p2);
      int pos;
      pos = int'(i[2:0]) * vic_pkg::FIELD_W;
      prio_of = vic_pkg::PRIO_NONE;
      if (int'(i) >= vic_pkg::LOW_FIRST && int'(i) < vic_pkg::MID_FIRST) begin
         prio_of = p0[pos +: vic_pkg::PRIO_W];
      end
      else if (int'(i) >= vic_pkg::MID_FIRST && int'(i) < vic_pkg::HIGH_FIRST) begin
         prio_of = p1[pos +: vic_pkg::PRIO_W];
      end
      else if (int'(i) >= vic_pkg::HIGH_FIRST && int'(i) <= vic_pkg::HIGH_LAST) begin
         prio_of = p2[pos +: vic_pkg::PRIO_W];
      end
   endfunction

   // Lowest level number wins, then lowest index
   function automatic vic_pkg::vic_win_type pick(input logic [31:0] act, input logic [31:0] p0,
                                                 input logic [31:0] p1, input logic [31:0] p2);
      vic_pkg::vic_win_type w;
      logic [2:0] l;
      w = '0;
      w.lvl = vic_pkg::PRIO_NONE;
      for (int k = 0; k < vic_pkg::NUM_SRC; k++) begin
         l = prio_of(5'(k), p0, p1, p2);
         if (act[k] && (!w.found || l < w.lvl)) begin
            w.found = 1'b1;
            w.idx = 5'(k);
            w.lvl = l;
         end
      end
      return w;
   endfunction

   // ======================================================
   // Registers
   logic [31:0] raw_reg;
   logic [31:0] nen_reg;
   logic [31:0] fen_reg;
   logic [31:0] swi_reg;
   logic [31:0] base_reg;
   logic [31:0] nvec_reg;
   logic [31:0] fvec_reg;
   logic [31:0] plow_reg;
   logic [31:0] pmid_reg;
   logic [31:0] phigh_reg;
   logic [31:0] rsvd_reg;
   logic [1:0] nest_reg;
   logic [31:0] trig_reg;
   logic [3:0] ext_prev_reg;
   logic [3:0] ext_latch_reg;
   logic [3:0] ext_latch_next;
   logic [3:0] ext_raw;
   vic_pkg::vic_stan_type nstan_reg;
   vic_pkg::vic_stan_type fstan_reg;

   logic [31:0] n_active;
   logic [31:0] f_active;
   vic_pkg::vic_win_type n_win;
   vic_pkg::vic_win_type f_win;
   logic n_gate;
   logic f_gate;

   logic hit;
   logic setup;
   logic wr_en;
   logic [11:0] ofs;
   logic [31:0] rd_data;
   logic rd_ok;

   // ======================================================
   // Bus decode
   // peripheral bus slave
   assign setup = apb_req.sel && !apb_req.enable;
   assign hit = (apb_req.addr & vic_pkg::REGION_MASK) == vic_pkg::BASE_ADDR;
   assign ofs = apb_req.addr[vic_pkg::OFS_W-1:0];
   // write lands on the access cycle
   assign wr_en = apb_req.sel && apb_req.enable && apb_req.write && apb_rsp.ready
                  && hit && !apb_rsp.slverr;

   always_ff @(posedge clk) begin
      if (rst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.ready <= setup;
         apb_rsp.slverr <= setup && !(hit && rd_ok);
         apb_rsp.rdata <= (setup && hit && !apb_req.write) ? rd_data : vic_pkg::RST_WORD;
      end
   end

   // ======================================================
   // Read mux
   always_comb begin
      rd_data = vic_pkg::RST_WORD;
      rd_ok = 1'b1;
      case (ofs)
         vic_pkg::OFS_NSTA: rd_data = n_active;
         vic_pkg::OFS_NSIG: rd_data = raw_reg;
         vic_pkg::OFS_NEN: rd_data = nen_reg;
         vic_pkg::OFS_NDIS: rd_data = vic_pkg::RST_WORD;
         vic_pkg::OFS_SWI: rd_data = vic_pkg::RST_WORD;
         vic_pkg::OFS_BASE: rd_data = base_reg;
         vic_pkg::OFS_NVEC: rd_data = nvec_reg;
         vic_pkg::OFS_PLOW: rd_data = plow_reg;
         vic_pkg::OFS_PMID: rd_data = pmid_reg;
         vic_pkg::OFS_PHIGH: rd_data = phigh_reg;
         vic_pkg::OFS_RSVD: rd_data = rsvd_reg;
         vic_pkg::OFS_NEST: rd_data = 32'(nest_reg);
         vic_pkg::OFS_TRIG: rd_data = trig_reg;
         vic_pkg::OFS_ECLR: rd_data = vic_pkg::RST_WORD;
         vic_pkg::OFS_NSTAN: rd_data = 32'(nstan_reg);
         vic_pkg::OFS_FSTA: rd_data = f_active;
         vic_pkg::OFS_FSIG: rd_data = raw_reg;
         vic_pkg::OFS_FEN: rd_data = fen_reg;
         vic_pkg::OFS_FDIS: rd_data = vic_pkg::RST_WORD;
         vic_pkg::OFS_FVEC: rd_data = fvec_reg;
         vic_pkg::OFS_FSTAN: rd_data = 32'(fstan_reg);
         default: rd_ok = 1'b0;
      endcase
   end

   // ======================================================
   // External triggers
   always_comb begin
      ext_latch_next = ext_latch_reg;
      ext_raw = '0;
      for (int e = 0; e < vic_pkg::NUM_EXT; e++) begin
         case (trig_reg[e*vic_pkg::TRIG_W +: vic_pkg::TRIG_W])
            vic_pkg::TRIG_RISE: begin
               if (wr_en && ofs == vic_pkg::OFS_ECLR && apb_req.wdata[e]) begin
                  ext_latch_next[e] = 1'b0;
               end
               if (ext_in[e] && !ext_prev_reg[e]) begin
                  ext_latch_next[e] = 1'b1;
               end
               ext_raw[e] = ext_latch_reg[e];
            end
            vic_pkg::TRIG_FALL: begin
               if (wr_en && ofs == vic_pkg::OFS_ECLR && apb_req.wdata[e]) begin
                  ext_latch_next[e] = 1'b0;
               end
               if (!ext_in[e] && ext_prev_reg[e]) begin
                  ext_latch_next[e] = 1'b1;
               end
               ext_raw[e] = ext_latch_reg[e];
            end
            default: begin
               ext_latch_next[e] = 1'b0;
               ext_raw[e] = ext_in[e];
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_prev_reg <= '0;
         ext_latch_reg <= '0;
      end else begin
         ext_prev_reg <= ext_in;
         ext_latch_reg <= ext_latch_next;
      end
   end

   // ======================================================
   // Raw sources
   always_ff @(posedge clk) begin
      if (rst) begin
         raw_reg <= vic_pkg::RST_WORD;
      end else begin
         // all sources, enabled or not; software sources
         raw_reg <= src_in | swi_reg | (32'(ext_raw) << vic_pkg::EXT_LSB);
      end
   end

   // ======================================================
   // Configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         swi_reg <= vic_pkg::RST_WORD;
         base_reg <= vic_pkg::RST_WORD;
         plow_reg <= vic_pkg::RST_WORD;
         pmid_reg <= vic_pkg::RST_WORD;
         phigh_reg <= vic_pkg::RST_WORD;
         rsvd_reg <= vic_pkg::RST_WORD;
         nest_reg <= '0;
         trig_reg <= vic_pkg::RST_WORD;
      end else if (wr_en) begin
         case (ofs)
            vic_pkg::OFS_SWI: swi_reg <= apb_req.wdata;
            vic_pkg::OFS_BASE: base_reg <= apb_req.wdata;
            vic_pkg::OFS_PLOW: plow_reg <= apb_req.wdata;
            vic_pkg::OFS_PMID: pmid_reg <= apb_req.wdata;
            vic_pkg::OFS_PHIGH: phigh_reg <= apb_req.wdata;
            vic_pkg::OFS_RSVD: rsvd_reg <= apb_req.wdata;
            vic_pkg::OFS_NEST: nest_reg <= apb_req.wdata[1:0];
            vic_pkg::OFS_TRIG: trig_reg <= apb_req.wdata;
            default: ;
         endcase
      end
   end

   // ======================================================
   // Enables
   always_ff @(posedge clk) begin
      if (rst) begin
         nen_reg <= vic_pkg::RST_WORD;
         fen_reg <= vic_pkg::RST_WORD;
      end else if (wr_en) begin
         if (ofs == vic_pkg::OFS_NEN) begin
            nen_reg <= nen_reg | apb_req.wdata;
         end
         if (ofs == vic_pkg::OFS_NDIS) begin
            nen_reg <= nen_reg & ~apb_req.wdata;
         end
         if (ofs == vic_pkg::OFS_FEN) begin
            fen_reg <= fen_reg | apb_req.wdata;
         end
         if (ofs == vic_pkg::OFS_FDIS) begin
            fen_reg <= fen_reg & ~apb_req.wdata;
         end
      end
   end

   // ======================================================
   // Arbitration
   // active is raw and enable
   assign n_active = raw_reg & nen_reg;
   assign f_active = raw_reg & fen_reg;
   assign n_win = pick(n_active, plow_reg, pmid_reg, phigh_reg);
   assign f_win = pick(f_active, plow_reg, pmid_reg, phigh_reg);
   // nested: only a strictly lower level number passes
   assign n_gate = !(nest_reg[vic_pkg::NEST_IRQ_BIT] && nstan_reg.valid) || n_win.lvl < nstan_reg.lvl;
   assign f_gate = !(nest_reg[vic_pkg::NEST_FIQ_BIT] && fstan_reg.valid) || f_win.lvl < fstan_reg.lvl;

   always_ff @(posedge clk) begin
      if (rst) begin
         nvec_reg <= vic_pkg::RST_WORD;
         fvec_reg <= vic_pkg::RST_WORD;
      end else begin
         nvec_reg <= n_win.found ? base_reg + (32'(n_win.idx) << vic_pkg::VEC_SHIFT) : vic_pkg::RST_WORD;
         fvec_reg <= f_win.found ? base_reg + (32'(f_win.idx) << vic_pkg::VEC_SHIFT) : vic_pkg::RST_WORD;
      end
   end

   // ======================================================
   // Requests to the core
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_req <= 1'b0;
         fiq_req <= 1'b0;
      end else begin
         fiq_req <= f_win.found && f_gate;
         irq_req <= n_win.found && n_gate && !(f_win.found && f_gate);
      end
   end

   // ======================================================
   // In-service levels
   always_ff @(posedge clk) begin
      if (rst) begin
         nstan_reg <= vic_pkg::STAN_IDLE;
         fstan_reg <= vic_pkg::STAN_IDLE;
      end else begin
         // record on normal entry, entry beats write
         if (irq_ack && n_win.found) begin
            nstan_reg <= {1'b1, n_win.lvl};
         end else if (wr_en && ofs == vic_pkg::OFS_NSTAN) begin
            nstan_reg <= apb_req.wdata[3:0];
         end
         if (fiq_ack && f_win.found) begin
            fstan_reg <= {1'b1, f_win.lvl};
         end else if (wr_en && ofs == vic_pkg::OFS_FSTAN) begin
            fstan_reg <= apb_req.wdata[3:0];
         end
      end
   end

   // ======================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_ready_after_setup: assert property (setup |=> apb_rsp.ready)
      else $error("ready missing after setup");
   a_ready_single: assert property (apb_rsp.ready |=> !apb_rsp.ready || $past(setup))
      else $error("ready held too long");
   a_outside_region: assert property (setup && !hit |=> apb_rsp.slverr)
      else $error("outside region not flagged");
   a_status_read: assert property (setup && hit && !apb_req.write && ofs == vic_pkg::OFS_NSTA
                                   |=> apb_rsp.rdata == $past(raw_reg & nen_reg))
      else $error("status read not raw and enable");
   a_disable_clears: assert property (wr_en && ofs == vic_pkg::OFS_NDIS
                                      |=> (nen_reg & $past(apb_req.wdata)) == '0)
      else $error("normal disable left bits set");
   a_fast_disable: assert property (wr_en && ofs == vic_pkg::OFS_FDIS
                                    |=> (fen_reg & $past(apb_req.wdata)) == '0)
      else $error("fast disable left bits set");
   a_fast_precedence: assert property (fiq_req |-> !irq_req)
      else $error("normal request beside fast");
   a_normal_entry: assert property (irq_ack && n_win.found
                                    |=> nstan_reg == {1'b1, $past(n_win.lvl)})
      else $error("normal level not recorded");
   a_fast_entry: assert property (fiq_ack && f_win.found
                                  |=> fstan_reg == {1'b1, $past(f_win.lvl)})
      else $error("fast level not recorded");
   a_fast_vec_idle: assert property (!f_win.found |=> fvec_reg == '0)
      else $error("fast vector not zero when idle");
   a_rise_latch: assert property (trig_reg[1:0] == vic_pkg::TRIG_RISE && ext_in[0] && !ext_prev_reg[0]
                                  |=> ext_latch_reg[0] ##1 raw_reg[vic_pkg::EXT_LSB])
      else $error("rising edge not latched");

   c_normal_req: cover property (!irq_req ##1 irq_req);
   c_fast_over_normal: cover property (n_win.found && f_win.found ##1 fiq_req);
   c_nested_entry: cover property (nest_reg[vic_pkg::NEST_IRQ_BIT] && nstan_reg.valid ##1 irq_req);
   c_edge_clear: cover property (ext_latch_reg[0] ##1 !ext_latch_reg[0]);

endmodule // vic_core

/* dv/vic_core_tb.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps

module vic_core_tb;
   logic clk;
   logic rst;
   vic_pkg::vic_apb_req_type apb_req;
   vic_pkg::vic_apb_rsp_type apb_rsp;
   logic [31:0] src_in;
   logic [3:0] ext_in;
   logic irq_ack;
   logic fiq_ack;
   logic irq_req;
   logic fiq_req;
   logic ack_en;
   logic [31:0] rd;
   logic [31:0] lat;
   logic err;
   int n_mismatch;
   int total_checks;
   logic [11:0] rst_tab [12] = '{vic_pkg::OFS_NSTA, vic_pkg::OFS_NEN, vic_pkg::OFS_BASE, vic_pkg::OFS_NVEC,
      vic_pkg::OFS_PLOW, vic_pkg::OFS_PMID, vic_pkg::OFS_PHIGH, vic_pkg::OFS_NEST, vic_pkg::OFS_TRIG,
      vic_pkg::OFS_NSTAN, vic_pkg::OFS_FVEC, vic_pkg::OFS_FSTAN};

   vic_core i_dut (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .src_in(src_in),
      .ext_in(ext_in), .irq_ack(irq_ack), .fiq_ack(fiq_ack), .irq_req(irq_req), .fiq_req(fiq_req));

   vic_cpu_model #(.LAT(3)) i_cpu (.clk(clk), .rst(rst), .ack_en(ack_en), .irq_req(irq_req),
      .fiq_req(fiq_req), .irq_ack(irq_ack), .fiq_ack(fiq_ack));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // =====================================================
   // Reporting
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // =====================================================
   // Peripheral bus transfers
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk);
      apb_req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: wd};
      @(posedge clk);
      apb_req.enable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         if (apb_rsp.ready === 1'b1) break;
      end
      if (i == 8) begin
         n_mismatch++;
         summarize();
      end
      lat = 32'(i);
      rd = apb_rsp.rdata;
      err = apb_rsp.slverr;
      apb_req <= '0;
   endtask

   task automatic wreg(input logic [11:0] ofs, input logic [31:0] wd);
      bus(1'b1, vic_pkg::BASE_ADDR | 32'(ofs), wd);
   endtask

   task automatic rreg(input logic [11:0] ofs, input logic [31:0] exp);
      bus(1'b0, vic_pkg::BASE_ADDR | 32'(ofs), 32'h00000000);
      chk(rd, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Lets the core model take one exception, bounded wait
   task automatic take_exc(input logic fast);
      int i;
      ack_en <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if ((fast ? fiq_ack : irq_ack) === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         summarize();
      end
      ack_en <= 1'b0;
   endtask

   // =====================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      apb_req = '0;
      src_in = 32'h00000000;
      ext_in = 4'h0;
      ack_en = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (rst_tab[k]) rreg(rst_tab[k], vic_pkg::RST_WORD);
      chk(lat, 32'h0);
      bus(1'b0, vic_pkg::BASE_ADDR | 32'h018, 32'h0);
      chk({31'h0, err}, 32'h1);
      bus(1'b0, 32'hFFFF1000, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      @(posedge clk);
      src_in <= 32'h00100224;
      tick(3);
      rreg(vic_pkg::OFS_NSIG, 32'h00100224);
      rreg(vic_pkg::OFS_FSIG, 32'h00100224);
      rreg(vic_pkg::OFS_NSTA, 32'h00000000);
      wreg(vic_pkg::OFS_BASE, 32'h00001000);
      wreg(vic_pkg::OFS_PLOW, 32'h00100300);
      wreg(vic_pkg::OFS_PMID, 32'h00000020);
      wreg(vic_pkg::OFS_NEN, 32'h00100224);
      tick(3);
      rreg(vic_pkg::OFS_NSTA, 32'h00100224);
      chk({31'h0, irq_req}, 32'h1);
      rreg(vic_pkg::OFS_NVEC, 32'h00001028);
      wreg(vic_pkg::OFS_PHIGH, 32'h00070000);
      tick(3);
      rreg(vic_pkg::OFS_NVEC, 32'h0000100A);
      wreg(vic_pkg::OFS_PMID, 32'h00000000);
      tick(3);
      rreg(vic_pkg::OFS_NVEC, 32'h00001012);
      wreg(vic_pkg::OFS_NDIS, 32'h00100204);
      tick(3);
      rreg(vic_pkg::OFS_NEN, 32'h00000020);
      rreg(vic_pkg::OFS_BASE, 32'h00001000);
      take_exc(1'b0);
      rreg(vic_pkg::OFS_NSTAN, 32'h00000009);
      wreg(vic_pkg::OFS_FEN, 32'h00000004);
      tick(3);
      rreg(vic_pkg::OFS_FSTA, 32'h00000004);
      rreg(vic_pkg::OFS_FVEC, 32'h00001004);
      chk({30'h0, fiq_req, irq_req}, 32'h2);
      take_exc(1'b1);
      rreg(vic_pkg::OFS_FSTAN, 32'h0000000B);
      wreg(vic_pkg::OFS_FDIS, 32'h00000004);
      tick(3);
      rreg(vic_pkg::OFS_FEN, 32'h00000000);
      chk({30'h0, fiq_req, irq_req}, 32'h1);
      @(posedge clk);
      src_in <= 32'h00000000;
      wreg(vic_pkg::OFS_SWI, 32'h00000008);
      tick(3);
      rreg(vic_pkg::OFS_NSIG, 32'h00000008);
      wreg(vic_pkg::OFS_SWI, 32'h00000000);
      wreg(vic_pkg::OFS_NEST, 32'h00000003);
      rreg(vic_pkg::OFS_NEST, 32'h00000003);
      // Nesting on, level 1 in service: equal level held back, lower number passes
      wreg(vic_pkg::OFS_SWI, 32'h00000020);
      tick(3);
      rreg(vic_pkg::OFS_NSTA, 32'h00000020);
      chk({31'h0, irq_req}, 32'h0);
      wreg(vic_pkg::OFS_NEN, 32'h00000200);
      wreg(vic_pkg::OFS_SWI, 32'h00000220);
      tick(3);
      chk({31'h0, irq_req}, 32'h1);
      rreg(vic_pkg::OFS_NVEC, 32'h00001012);
      wreg(vic_pkg::OFS_NDIS, 32'h00000200);
      wreg(vic_pkg::OFS_SWI, 32'h00000000);
      // Input 0 rising, input 1 falling, input 2 level
      wreg(vic_pkg::OFS_TRIG, 32'h00000009);
      @(posedge clk);
      ext_in <= 4'h3;
      tick(4);
      ext_in <= 4'h0;
      tick(4);
      rreg(vic_pkg::OFS_NSIG, 32'h00030000);
      wreg(vic_pkg::OFS_ECLR, 32'h00000001);
      @(posedge clk);
      ext_in <= 4'h4;
      tick(3);
      rreg(vic_pkg::OFS_NSIG, 32'h00060000);
      // Mid-run reset drops nesting and in-service records
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      rreg(vic_pkg::OFS_NEST, 32'h00000000);
      rreg(vic_pkg::OFS_NSTAN, 32'h00000000);
      rreg(vic_pkg::OFS_FSTAN, 32'h00000000);
      summarize();
   end
endmodule // vic_core_tb

/* dv/vic_cpu_model.sv */
// Behavioural processor core that takes interrupt exceptions
`timescale 1ns/1ps

module vic_cpu_model #(
   parameter int LAT = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench control
   input wire logic ack_en,
   // Requests and exception entry
   input wire logic irq_req,
   input wire logic fiq_req,
   output logic irq_ack,
   output logic fiq_ack
);
   int cnt;
   logic done;

   // =====================================================
   // One exception entry per enable, after LAT cycles
   always_ff @(posedge clk) begin
      irq_ack <= 1'b0;
      fiq_ack <= 1'b0;
      if (rst || !ack_en) begin
         cnt <= 0;
         done <= 1'b0;
      end else if (!done && (fiq_req || irq_req)) begin
         if (cnt == LAT) begin
            fiq_ack <= fiq_req;
            irq_ack <= !fiq_req;
            done <= 1'b1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule // vic_cpu_model
